// ==== rtl/tcgp_pkg.sv ====
// Constants, mode codes and state type for the gated/compare timer.
// Assumes a single system clock; every user holds this package by import.
//
// Behaviour
// - Compare mode counts only prescaled system clock
// - Compare interval is (compare-start+1) times prescale
// - Gated mode counts only while input active
// - Gated interrupt on deassertion and on reload
// - Gated reload interrupts and restarts count at 0001H
// - Gated reload toggles output when output enabled
// - Single PWM: idle pol, match active, reload idle
// - Capture count on polarity-selected input edge
// - Compare output equals polarity, inverts per reload
// - Gated polarity picks count level, interrupt edge
// - Capture/compare starts on first edge, then captures
// - Dual PWM: complementary outputs, polarity inverts all
// - Dual PWM delay cycles before outputs go active
package tcgp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int CNT_W   = 16;            // Counter width
    localparam int MODE_W  = 3;             // Mode field width
    localparam int PRESC_W = 3;             // Prescale exponent width
    localparam int PDIV_W  = 7;             // Prescale divider width (up to 128)
    localparam int DLY_W   = 3;             // Deadband delay field width

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0]  COUNT_RST   = 16'h0001; // Count after reset
    localparam logic [CNT_W-1:0]  COUNT_RESTART = 16'h0001; // Count after reload
    localparam logic [CNT_W-1:0]  CAPT_RST    = 16'h0000; // Capture register reset
    localparam logic [PDIV_W-1:0] PDIV_RST    = 7'h00;    // Divider reset
    localparam logic [DLY_W-1:0]  DLY_RST     = 3'h0;     // Deadband counter reset

    // ------------------------------------------------------------
    // Mode codes
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_COMPARE  = 3'h0;
    localparam logic [MODE_W-1:0] MODE_GATED    = 3'h1;
    localparam logic [MODE_W-1:0] MODE_CAPTURE  = 3'h2;
    localparam logic [MODE_W-1:0] MODE_CAPCMP   = 3'h3;
    localparam logic [MODE_W-1:0] MODE_PWM_SGL  = 3'h4;
    localparam logic [MODE_W-1:0] MODE_PWM_DUAL = 3'h5;

    // ------------------------------------------------------------
    // Run state, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TCGP_IDLE  = 3'b001,   // Disabled
        TCGP_ARMED = 3'b010,   // Waiting for first input edge
        TCGP_RUN   = 3'b100    // Counting
    } tcgp_state_t;

endpackage : tcgp_pkg

// ==== rtl/tcgp_deadband.sv ====
// Deadband delay stage for one PWM output.
// Assumes req is a level on the same clock; act_q rises delay+1 cycles
// after req rises and falls one cycle after req falls.
`timescale 1ns/1ps

module tcgp_deadband
    import tcgp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Request and delay
    input  wire logic             req,
    input  wire logic [DLY_W-1:0] delay,
    // Delayed active level
    output logic                  act_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [DLY_W-1:0] cnt_q;   // Cycles waited so far
    logic [DLY_W-1:0] cnt_d;
    logic             act_d;

    // Next-state: release at once, assert only after the delay
    always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (!req) begin
            cnt_d = DLY_RST;
            act_d = 1'b0;
        end else if (!act_q) begin
            if (cnt_q == delay) begin
                act_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    // Registers; clock enable freezes them
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= DLY_RST;
            act_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end

endmodule : tcgp_deadband

// ==== rtl/tcgp_timer.sv ====
// Sixteen-bit timer with compare, gated, capture, capture/compare and
// single/dual PWM modes. Configuration arrives as plain ports from a
// register block outside; the timer input pin is asynchronous.
`timescale 1ns/1ps

module tcgp_timer
    import tcgp_pkg::*;
(
    // Clock, reset, clock enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Control
    input  wire logic              timer_enable,
    input  wire logic [MODE_W-1:0] mode,
    input  wire logic              input_polarity_select,
    input  wire logic [PRESC_W-1:0] prescale,
    input  wire logic [DLY_W-1:0]  pwm_deadband_delay,
    input  wire logic              gated_out_enable,
    // Values
    input  wire logic [CNT_W-1:0]  reload_value,
    input  wire logic [CNT_W-1:0]  pwm_value,
    input  wire logic              count_load,
    input  wire logic [CNT_W-1:0]  count_load_value,
    // Timer pins
    input  wire logic              timer_in,
    output logic                   timer_out,
    output logic                   timer_out_comp,
    // Status
    output logic [CNT_W-1:0]       count,
    output logic [CNT_W-1:0]       capture_value,
    output logic                   capture_strobe,
    output logic                   timer_irq,
    output logic                   timer_running
);

    // ------------------------------------------------------------
    // Prescale decode
    // ------------------------------------------------------------
    // Terminal divider value for a 2**prescale division
    function automatic logic [PDIV_W-1:0] presc_last(input logic [PRESC_W-1:0] p);
        logic [PDIV_W:0] one_hot;
        one_hot    = '0;
        one_hot[p] = 1'b1;
        presc_last = PDIV_W'(one_hot - 8'h01);
    endfunction : presc_last

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic sync1_q;   // First stage, read only by second stage
    logic sync2_q;   // Safe level
    logic prev_q;    // Previous safe level for edge detect

    // Two flops against metastability, a third for edges
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else if (ce) begin
            sync1_q <= timer_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    logic in_rise;      // Rising edge of synchronised input
    logic in_fall;      // Falling edge
    logic sel_edge;     // Edge chosen by polarity
    logic deassert;     // Input leaving its active level
    logic in_active;    // Input at its active level

    assign in_rise   = sync2_q & ~prev_q;
    assign in_fall   = ~sync2_q & prev_q;
    assign sel_edge  = input_polarity_select ? in_fall : in_rise;
    assign deassert  = input_polarity_select ? in_rise : in_fall;
    assign in_active = sync2_q ^ input_polarity_select;

    // ------------------------------------------------------------
    // Run state machine
    // ------------------------------------------------------------
    tcgp_state_t state_q;
    tcgp_state_t state_d;

    // Disabled drops to idle; capture/compare waits for its first edge
    always_comb begin
        state_d = state_q;
        case (state_q)
            TCGP_IDLE: begin
                if (timer_enable) begin
                    state_d = (mode == MODE_CAPCMP) ? TCGP_ARMED : TCGP_RUN;
                end
            end
            TCGP_ARMED: begin
                if (!timer_enable) begin
                    state_d = TCGP_IDLE;
                end else if (sel_edge) begin
                    state_d = TCGP_RUN;
                end
            end
            TCGP_RUN: begin
                if (!timer_enable) begin
                    state_d = TCGP_IDLE;
                end
            end
            default: begin
                state_d = TCGP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= TCGP_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------
    logic [PDIV_W-1:0] pdiv_q;       // Prescale divider
    logic [PDIV_W-1:0] pdiv_d;
    logic [CNT_W-1:0]  count_q;      // Main count
    logic [CNT_W-1:0]  count_d;
    logic [CNT_W-1:0]  capt_q;       // Captured count
    logic [CNT_W-1:0]  capt_d;
    logic              capt_stb_q;   // Capture pulse
    logic              capt_stb_d;
    logic              irq_q;        // Interrupt pulse
    logic              irq_d;
    logic              phase_q;      // Output phase: 1 = active
    logic              phase_d;

    logic cnt_allow;   // Counting permitted this cycle
    logic tick;        // One prescaled count step
    logic reload_evt;  // Count hit the reload value
    logic match_evt;   // Count hit the PWM value
    logic capt_evt;    // Capture edge accepted
    logic is_pwm;      // Either PWM mode

    // Count source is always the system clock; the pin only gates it
    assign cnt_allow  = (state_q == TCGP_RUN) &&
                        ((mode != MODE_GATED) || in_active);
    assign tick       = cnt_allow && (pdiv_q == presc_last(prescale));
    assign reload_evt = tick && (count_q == reload_value);
    assign match_evt  = tick && (count_q == pwm_value);
    assign capt_evt   = (state_q == TCGP_RUN) && sel_edge &&
                        ((mode == MODE_CAPTURE) || (mode == MODE_CAPCMP));
    assign is_pwm     = (mode == MODE_PWM_SGL) || (mode == MODE_PWM_DUAL);

    // Next values for divider, count, capture, interrupt and phase
    always_comb begin
        pdiv_d     = pdiv_q;
        count_d    = count_q;
        capt_d     = capt_q;
        capt_stb_d = 1'b0;
        irq_d      = 1'b0;
        phase_d    = phase_q;

        // Divider only runs while counting is allowed, so a gate pause
        // keeps the partial prescale period instead of losing it
        if (!cnt_allow) begin
            pdiv_d = pdiv_q;
        end else if (tick) begin
            pdiv_d = PDIV_RST;
        end else begin
            pdiv_d = pdiv_q + 7'h01;
        end
        if (state_q == TCGP_IDLE) begin
            pdiv_d = PDIV_RST;
        end

        // Count: software load wins over a step in the same cycle
        if (count_load) begin
            count_d = count_load_value;
        end else if (reload_evt) begin
            count_d = COUNT_RESTART;
        end else if (tick) begin
            count_d = count_q + 16'h0001;
        end

        // Capture of the running count
        if (capt_evt) begin
            capt_d     = count_q;
            capt_stb_d = 1'b1;
        end

        // Interrupt sources
        if (reload_evt) begin
            irq_d = 1'b1;
        end
        if ((state_q == TCGP_RUN) && (mode == MODE_GATED) && deassert) begin
            irq_d = 1'b1;
        end
        if (capt_evt) begin
            irq_d = 1'b1;
        end

        // Output phase
        if (state_q == TCGP_IDLE) begin
            phase_d = 1'b0;
        end else if (is_pwm) begin
            if (reload_evt) begin
                phase_d = 1'b0;
            end else if (match_evt) begin
                phase_d = 1'b1;
            end
        end else if (mode == MODE_COMPARE) begin
            if (reload_evt) begin
                phase_d = ~phase_q;
            end
        end else if (mode == MODE_GATED) begin
            if (reload_evt && gated_out_enable) begin
                phase_d = ~phase_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pdiv_q     <= PDIV_RST;
            count_q    <= COUNT_RST;
            capt_q     <= CAPT_RST;
            capt_stb_q <= 1'b0;
            irq_q      <= 1'b0;
            phase_q    <= 1'b0;
        end else if (ce) begin
            pdiv_q     <= pdiv_d;
            count_q    <= count_d;
            capt_q     <= capt_d;
            capt_stb_q <= capt_stb_d;
            irq_q      <= irq_d;
            phase_q    <= phase_d;
        end
    end

    // ------------------------------------------------------------
    // Dual PWM deadband
    // ------------------------------------------------------------
    logic out_act;    // Main output allowed active
    logic comp_act;   // Complement allowed active

    // Both edges toward the active level are held back by the delay,
    // so the two outputs are never active together
    tcgp_deadband u_db_out (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .req   (phase_q),
        .delay (pwm_deadband_delay),
        .act_q (out_act)
    );

    tcgp_deadband u_db_comp (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .req   (~phase_q),
        .delay (pwm_deadband_delay),
        .act_q (comp_act)
    );

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    logic out_q;     // Registered timer output
    logic out_d;
    logic comp_q;    // Registered complement
    logic comp_d;

    // Active level is the inverse of the polarity bit in every mode
    always_comb begin
        if (mode == MODE_PWM_DUAL) begin
            out_d  = out_act ^ input_polarity_select;
            comp_d = comp_act ^ input_polarity_select;
        end else begin
            out_d  = phase_q ^ input_polarity_select;
            comp_d = ~out_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_q  <= 1'b0;
            comp_q <= 1'b1;
        end else if (ce) begin
            out_q  <= out_d;
            comp_q <= comp_d;
        end
    end

    // ------------------------------------------------------------
    // Status outputs, all from flops
    // ------------------------------------------------------------
    assign timer_out      = out_q;
    assign timer_out_comp = comp_q;
    assign count          = count_q;
    assign capture_value  = capt_q;
    assign capture_strobe = capt_stb_q;
    assign timer_irq      = irq_q;
    assign timer_running  = (state_q == TCGP_RUN);

endmodule : tcgp_timer

// ==== verif/tcgp_pin_model.sv ====
// Far-side driver of the timer input pin.
// Assumes one clock; the pin follows the commanded level after lag+1 cycles.
`timescale 1ns/1ps

module tcgp_pin_model (
    // Clock
    input  wire logic       clk,
    // Command: wanted level and extra delay
    input  wire logic       lvl,
    input  wire logic [3:0] lag,
    // Pin
    output logic            timer_in
);
    // ------------------------------------------------
    // Delayed follower, so slow sources are modelled too
    // ------------------------------------------------
    logic [3:0] n_q = 4'h0; // Cycles waited so far
    initial timer_in = 1'b0;
    always @(posedge clk) begin
        if (timer_in == lvl) begin
            n_q <= 4'h0;             // Settled: nothing pending
        end else if (n_q >= lag) begin
            timer_in <= lvl;         // Change lands on a clock edge only
        end else begin
            n_q <= n_q + 4'h1;
        end
    end
endmodule : tcgp_pin_model

// ==== verif/tcgp_timer_props.sv ====
// Checker on the timer's top ports, attached by bind.
// Assumes ce is held high and timer_in only moves on clock edges.
`timescale 1ns/1ps

module tcgp_timer_props
    import tcgp_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Control
    input wire logic              timer_enable,
    input wire logic [MODE_W-1:0] mode,
    input wire logic              input_polarity_select,
    input wire logic [CNT_W-1:0]  reload_value,
    input wire logic              count_load,
    // Pins and status
    input wire logic              timer_in,
    input wire logic              timer_out,
    input wire logic              timer_out_comp,
    input wire logic [CNT_W-1:0]  count,
    input wire logic              capture_strobe,
    input wire logic              timer_irq,
    input wire logic              timer_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------
    // Helpers: pin history, disabled-cycle count
    // ------------------------------------------------
    logic [5:0] hist_q; // Last six pin samples, covers the synchroniser
    logic       pol_q;  // Polarity one cycle ago
    logic [3:0] dis_q;  // Cycles disabled, saturating; deadband may take 11
    always_ff @(posedge clk) begin
        hist_q <= {hist_q[4:0], timer_in};
        pol_q  <= input_polarity_select;
        if (rst || timer_enable || pol_q != input_polarity_select) begin
            dis_q <= 4'h0;
        end else if (dis_q != 4'hF) begin
            dis_q <= dis_q + 4'h1;
        end
    end
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    a_idle_hold: assert property (
        !timer_running && !count_load |=> $stable(count))
        else $error("Count moved while stopped");
    a_count_step: assert property (
        $past(timer_running) && !$past(count_load) && count != $past(count)
        |-> count == $past(count) + 16'h0001 || count == COUNT_RESTART)
        else $error("Count stepped by other than one");
    a_reload_restart: assert property (
        (mode == MODE_COMPARE || mode == MODE_GATED) && !$past(count_load)
        && $past(count) == $past(reload_value) && count != $past(count)
        |-> count == COUNT_RESTART)
        else $error("Reload did not restart at one");
    a_gated_hold: assert property (
        mode == MODE_GATED && $past(mode) == MODE_GATED && !$past(count_load)
        && pol_q == input_polarity_select && hist_q == {6{input_polarity_select}}
        |-> $stable(count))
        else $error("Gated count moved while input inactive");
    a_idle_level: assert property (
        dis_q >= 4'hC |-> timer_out == input_polarity_select
        && timer_out_comp == !input_polarity_select)
        else $error("Disabled output levels wrong");
    a_strobe_single: assert property (
        capture_strobe |-> timer_irq ##1 !capture_strobe)
        else $error("Capture strobe not a single pulse with irq");
    a_capture_edge: assert property (
        mode == MODE_CAPTURE && timer_running && $changed(timer_in)
        && timer_in != input_polarity_select |-> ##[2:5] capture_strobe)
        else $error("Selected edge not captured");
    a_gated_deassert: assert property (
        mode == MODE_GATED && timer_running && $changed(timer_in)
        && timer_in == input_polarity_select |-> ##[2:5] timer_irq)
        else $error("No irq on gated deassert");
endmodule : tcgp_timer_props

bind tcgp_timer tcgp_timer_props u_props (
    .clk, .rst, .timer_enable, .mode, .input_polarity_select, .reload_value,
    .count_load, .timer_in, .timer_out, .timer_out_comp, .count,
    .capture_strobe, .timer_irq, .timer_running
);

// ==== verif/tb_top.sv ====
// Self-checking bench for the timer: configure, drive the pin, compare.
// Assumes the pin model and bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_top import tcgp_pkg::*; ;
    // ------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------
    logic               clk = 1'b0, rst = 1'b1, timer_enable = 1'b0;
    logic               input_polarity_select = 1'b0, gated_out_enable = 1'b0;
    logic               count_load = 1'b0, pin_lvl = 1'b0, o0;
    logic [MODE_W-1:0]  mode = MODE_COMPARE;
    logic [PRESC_W-1:0] prescale = 3'h0;
    logic [DLY_W-1:0]   pwm_deadband_delay = 3'h0;
    logic [CNT_W-1:0]   reload_value = 16'hFFFF, pwm_value = 16'h0000;
    logic [CNT_W-1:0]   count_load_value = 16'h0001, count, capture_value, c0;
    logic [3:0]         pin_lag = 4'h0;
    logic               timer_in, timer_out, timer_out_comp;
    logic               capture_strobe, timer_irq, timer_running;
    int                 n_fail = 0, checks_done = 0, n_strobe = 0, n0, t0, t1;
    int                 dl [4];

    always #2.5 clk = ~clk;
    always @(posedge clk) if (capture_strobe === 1'b1) n_strobe <= n_strobe + 1;

    tcgp_timer dut (
        .clk, .rst, .ce(1'b1), .timer_enable, .mode, .input_polarity_select,
        .prescale, .pwm_deadband_delay, .gated_out_enable, .reload_value,
        .pwm_value, .count_load, .count_load_value, .timer_in, .timer_out,
        .timer_out_comp, .count, .capture_value, .capture_strobe, .timer_irq,
        .timer_running
    );
    tcgp_pin_model u_pin (.clk, .lvl(pin_lvl), .lag(pin_lag), .timer_in);

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic chk(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Waits on irq (0), strobe (1) or PWM match (2); counts cycles
    task automatic wait_for(input int what, output int t);
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (!(what == 0 ? timer_irq === 1'b1 : what == 1 ?
                     capture_strobe === 1'b1 : count === pwm_value) && t < 300);
        if (t >= 300) n_fail++; // Limit ran out: counts as a mismatch
    endtask : wait_for

    // Disable, set up, load start, set values, check idle levels, enable
    task automatic cfg(input logic [MODE_W-1:0] m, input logic p,
                       input logic [PRESC_W-1:0] ps, input logic [CNT_W-1:0] rl,
                       input logic [CNT_W-1:0] pw, input logic pl);
        @(posedge clk) timer_enable <= 1'b0;
        @(posedge clk) begin
            mode <= m;
            input_polarity_select <= p;
            prescale <= ps;
            pin_lvl <= pl;
        end
        @(posedge clk) count_load <= 1'b1;
        @(posedge clk) begin
            count_load <= 1'b0;
            reload_value <= rl;
            pwm_value <= pw;
        end
        repeat (12) @(negedge clk);
        chk(timer_out, p);
        chk(timer_out_comp, !p);
        @(posedge clk) timer_enable <= 1'b1;
    endtask : cfg

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    // ------------------------------------------------
    // Watchdog: whole run is under a thousand cycles
    // ------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    // ------------------------------------------------
    // Test sequence
    // ------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Compare: steady period, pin wiggle must not matter
        cfg(MODE_COMPARE, 1'b0, 3'h2, 16'h0005, 16'h0000, 1'b1);
        wait_for(0, t0);
        @(posedge clk) pin_lvl <= 1'b0;
        wait_for(0, t1);
        chk(t1, 20);
        repeat (3) @(negedge clk);
        o0 = timer_out;
        wait_for(0, t1);
        repeat (3) @(negedge clk);
        chk(timer_out, !o0);
        // Gated, both polarities: hold, reload toggle, deassert irq
        @(posedge clk) gated_out_enable <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            cfg(MODE_GATED, p[0], 3'h0, 16'h0010, 16'h0000, p[0]);
            repeat (10) @(negedge clk);
            c0 = count;
            repeat (10) @(negedge clk);
            chk(count, c0);
            o0 = timer_out;
            @(posedge clk) pin_lvl <= !p[0];
            wait_for(0, t1);
            repeat (3) @(negedge clk);
            chk(timer_out, !o0);
            @(posedge clk) pin_lvl <= p[0];
            wait_for(0, t1);
            chk(t1 < 8, 1'b1);
            chk(timer_in, p[0]);
        end
        // Capture, both polarities, with a slow pin source
        pin_lag <= 4'h3;
        for (int p = 0; p < 2; p++) begin
            cfg(MODE_CAPTURE, p[0], 3'h0, 16'hFFFF, 16'h0000, p[0]);
            n0 = n_strobe;
            @(posedge clk) pin_lvl <= !p[0];
            wait_for(1, t1);
            chk(capture_value, count - 16'h0001);
            @(posedge clk) pin_lvl <= p[0];
            repeat (12) @(negedge clk);
            chk(n_strobe - n0, 1);
        end
        // Capture/compare: idle until first rising edge, then capture
        cfg(MODE_CAPCMP, 1'b0, 3'h0, 16'hFFFF, 16'h0000, 1'b0);
        repeat (10) @(negedge clk);
        chk(timer_running, 1'b0);
        @(posedge clk) pin_lvl <= 1'b1;
        repeat (10) @(negedge clk);
        chk(timer_running, 1'b1);
        @(posedge clk) pin_lvl <= 1'b0;
        repeat (8) @(negedge clk);
        @(posedge clk) pin_lvl <= 1'b1;
        wait_for(1, t1);
        chk(capture_value, count - 16'h0001);
        // PWM single and dual, both polarities; dual uses deadband 0 or 4
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) pwm_deadband_delay <= k[0] ? 3'h4 : 3'h0;
            cfg(k[1] ? MODE_PWM_DUAL : MODE_PWM_SGL, k[0], 3'h0, 16'h0030,
                16'h0010, 1'b0);
            wait_for(2, t1);
            t0 = 0;
            while (timer_out !== !k[0] && t0 < 20) begin
                @(negedge clk);
                t0++;
            end
            dl[k] = t0;
            repeat (3) @(negedge clk);
            chk(timer_out_comp, !timer_out);
            chk(timer_out, !k[0]);
            wait_for(0, t1);
            repeat (8) @(negedge clk);
            chk(timer_out, k[0]);
            chk(timer_out_comp, !k[0]);
        end
        chk(dl[3] - dl[2], 4);
        conclude();
    end
endmodule : tb_top
